// ==== hw/rtcc_ctrl.sv ====
// rtcc_ctrl: control and status registers of the real-time clock
// assumes a byte-wide register port on mclk; alarm match comes from
// the alarm compare logic and valid_ram_time_in from the time-keeping logic
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module rtcc_ctrl
	import rtcc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// events from the time-keeping logic
	input wire logic alarm_match,
	input wire logic valid_ram_time_in,
	// time-keeping controls
	output logic transfer_allow,
	output logic second_tick,
	output logic update_in_progress,
	output logic data_format,
	output logic hour_format,
	output logic daylight_saving_enable,
	// interrupt request and square wave
	output logic irq_req,
	output logic square_wave_output
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	// keep-on-reset bits are loaded by software writes, except valid_ram_time, which follows its pin
	logic src_hi;
	logic [1:0] src_lo;
	logic [3:0] rate_select;
	logic transfer_inhibit;
	logic periodic_irq_enable;
	logic alarm_irq_enable;
	logic update_irq_enable;
	logic square_wave_enable;
	logic periodic_flag;
	logic alarm_flag;
	logic update_flag;
	logic slow_clock_output_enable;
	logic valid_ram_time;
	logic alarm_sync1;
	logic alarm_sync2;
	logic alarm_prev;
	logic valid_sync1;
	logic rate_tap_prev;
	logic square_reg;
	rtcc_upd_e upd_state;

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	wire [2:0] clock_source_control = {src_hi, src_lo};
	wire wr_osc = reg_wr & hit(reg_addr, ADDR_OSC_RATE);
	wire wr_fmt = reg_wr & hit(reg_addr, ADDR_IRQ_FMT);
	wire flags_rw = clock_source_control == SRC_RUN_FLAGS_RW;
	wire wr_evt = reg_wr & hit(reg_addr, ADDR_EVENTS) & flags_rw;
	wire rd_evt = reg_rd & hit(reg_addr, ADDR_EVENTS);
	// writes to the integrity register or to unmapped offsets decode to
	// no strobe at all, so they fall away without touching any state

	// source control decode
	wire osc_only = clock_source_control[2:1] == SRC_OSC_ONLY_HI;
	wire div_run = (clock_source_control == SRC_RUN) | flags_rw;
	wire osc_run = div_run | osc_only;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	logic osc_tick;
	logic [DIV_W-1:0] stages;

	// both time-base stages restart from zero on every reset, so the first
	// periodic event after reset comes half a tap period after the divider starts
	rtcc_tick_gen i_rtcc_tick_gen (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.osc_run(osc_run),
		.osc_tick(osc_tick)
	);

	rtcc_divider i_rtcc_divider (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.osc_tick(osc_tick),
		.div_run(div_run),
		.stages(stages),
		.second_tick(second_tick)
	);

	// rate select picks a divider tap; 0 means none
	// select one picks the last stage, stage 14, the slowest tap; the clamp
	// only catches select zero, which is gated off anyway
	wire [3:0] tap_idx = 4'(15) - rate_select;
	wire rate_tap = (rate_select != RATE_OFF) &
		stages[tap_idx[3:0] >= 4'(DIV_W) ? 4'(DIV_W-1) : tap_idx];
	wire periodic_evt = rate_tap & ~rate_tap_prev;

	// alarm match edge from the synchronised pin
	wire alarm_evt = alarm_sync2 & ~alarm_prev;

	// update cycle: busy for one oscillator tick after each second
	wire update_end = (upd_state == RTCC_UPDATING) & osc_tick;

	// ----------------------------------------------------------------
	// flag and pending logic
	// ----------------------------------------------------------------
	wire [2:0] flag_vec = {periodic_flag, alarm_flag, update_flag};
	wire [2:0] en_vec = {periodic_irq_enable, alarm_irq_enable,
		update_irq_enable};
	wire irq_pending_flag = |(flag_vec & en_vec);

	// a read clears the flags, but a new event wins over the clear
	// hazard: an event landing with the read strobe would otherwise be lost
	// between the byte software saw and the flag going low
	wire next_periodic_flag = periodic_evt |
		(wr_evt ? reg_wdata[BIT_PERIODIC_FLAG] : (periodic_flag & ~rd_evt));
	wire next_alarm_flag = alarm_evt |
		(wr_evt ? reg_wdata[BIT_ALARM_FLAG] : (alarm_flag & ~rd_evt));
	wire next_update_flag = update_end |
		(wr_evt ? reg_wdata[BIT_UPDATE_FLAG] : (update_flag & ~rd_evt));

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// each register byte assembled from live state; unmapped offsets read
	// as zero so a stray read never shows stale data
	wire [7:0] osc_byte = {update_in_progress, clock_source_control,
		rate_select};
	wire [7:0] fmt_byte = {transfer_inhibit, periodic_irq_enable,
		alarm_irq_enable, update_irq_enable, square_wave_enable,
		data_format, hour_format, daylight_saving_enable};
	wire [7:0] evt_byte = {irq_pending_flag, periodic_flag, alarm_flag,
		update_flag, 1'b0, slow_clock_output_enable, 2'b00};
	wire [7:0] int_byte = {valid_ram_time, 7'h00};
	wire [7:0] rd_mux = hit(reg_addr, ADDR_OSC_RATE) ? osc_byte :
		hit(reg_addr, ADDR_IRQ_FMT) ? fmt_byte :
		hit(reg_addr, ADDR_EVENTS) ? evt_byte :
		hit(reg_addr, ADDR_INTEGRITY) ? int_byte : BYTE_ZERO;

	// read data stands in the cycle after the strobe only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= BYTE_ZERO;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : BYTE_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// resettable control bits
	// ----------------------------------------------------------------
	// enables and flags clear on reset; update enable cleared by inhibit
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			src_lo <= SRC_RESET_LO[1:0];
			periodic_irq_enable <= 1'b0;
			alarm_irq_enable <= 1'b0;
			update_irq_enable <= 1'b0;
			square_wave_enable <= 1'b0;
			periodic_flag <= 1'b0;
			alarm_flag <= 1'b0;
			update_flag <= 1'b0;
			slow_clock_output_enable <= 1'b0;
		end else begin
			if (wr_osc)
				src_lo <= reg_wdata[BIT_SRC_LO+1:BIT_SRC_LO];
			if (wr_fmt) begin
				periodic_irq_enable <= reg_wdata[BIT_PERIODIC_EN];
				alarm_irq_enable <= reg_wdata[BIT_ALARM_EN];
				square_wave_enable <= reg_wdata[BIT_SQUARE_EN];
			end
			if (wr_fmt)
				update_irq_enable <= reg_wdata[BIT_UPDATE_EN] &
					~reg_wdata[BIT_TRANSFER_INHIBIT];
			else if (transfer_inhibit)
				update_irq_enable <= 1'b0;
			periodic_flag <= next_periodic_flag;
			alarm_flag <= next_alarm_flag;
			update_flag <= next_update_flag;
			if (wr_evt)
				slow_clock_output_enable <=
					reg_wdata[BIT_SLOW_CLK_EN];
		end
	end

	// ----------------------------------------------------------------
	// bits that keep their value over reset
	// ----------------------------------------------------------------
	// no reset branch: these survive a reset pulse
	// limitation: the written bits start unknown at power-up until software has
	// written both control registers once; valid_ram_time is known after two mclk edges
	always_ff @(posedge mclk) begin
		if (wr_osc) begin
			src_hi <= reg_wdata[BIT_SRC_HI];
			rate_select <= reg_wdata[3:0];
		end
		if (wr_fmt) begin
			transfer_inhibit <= reg_wdata[BIT_TRANSFER_INHIBIT];
			data_format <= reg_wdata[BIT_DATA_FORMAT];
			hour_format <= reg_wdata[BIT_HOUR_FORMAT];
			daylight_saving_enable <= reg_wdata[BIT_DAYLIGHT];
		end
		valid_sync1 <= valid_ram_time_in;
		valid_ram_time <= valid_sync1;
	end

	// ----------------------------------------------------------------
	// synchronisers and update sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			alarm_sync1 <= 1'b0;
			alarm_sync2 <= 1'b0;
			alarm_prev <= 1'b0;
			rate_tap_prev <= 1'b0;
		end else begin
			alarm_sync1 <= alarm_match;
			alarm_sync2 <= alarm_sync1;
			alarm_prev <= alarm_sync2;
			rate_tap_prev <= rate_tap;
		end
	end

	// update cycle state; busy flag is read-only to software
	// the busy window lasts one oscillator tick; transfer_allow pulses
	// once at its end and never while transfer_inhibit is set
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			upd_state <= RTCC_IDLE;
		end else begin
			unique case (upd_state)
				RTCC_IDLE: begin
					if (second_tick)
						upd_state <= RTCC_UPDATING;
				end
				RTCC_UPDATING: begin
					if (osc_tick)
						upd_state <= RTCC_DONE;
				end
				RTCC_DONE: begin
					upd_state <= RTCC_IDLE;
				end
			endcase
		end
	end

	assign update_in_progress = upd_state == RTCC_UPDATING;
	assign transfer_allow = update_end & ~transfer_inhibit;
	assign irq_req = irq_pending_flag;

	// ----------------------------------------------------------------
	// square wave output
	// ----------------------------------------------------------------
	// in the 011 mode the slow clock wins over the rate tap; stage 0 runs
	// at half the tick rate, the nearest whole-cycle clock on mclk
	wire slow_out = flags_rw & slow_clock_output_enable;
	wire osc_half = stages[0];
	wire next_square = slow_out ? osc_half :
		(square_wave_enable & rate_tap);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			square_reg <= 1'b0;
		end else begin
			square_reg <= next_square;
		end
	end

	assign square_wave_output = square_reg;

endmodule // rtcc_ctrl

// ==== pkg/rtcc_pkg.sv ====
// rtcc_pkg: offsets, field positions and constants of the rtc control block
// assumes nothing beyond a byte-wide register port
package rtcc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OSC_RATE = 8'h0a;
	localparam logic [7:0] ADDR_IRQ_FMT = 8'h0b;
	localparam logic [7:0] ADDR_EVENTS = 8'h0c;
	localparam logic [7:0] ADDR_INTEGRITY = 8'h0d;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_UPDATE_IN_PROGRESS = 7;
	localparam int BIT_SRC_HI = 6;
	localparam int BIT_SRC_LO = 4;
	localparam int BIT_TRANSFER_INHIBIT = 7;
	localparam int BIT_PERIODIC_EN = 6;
	localparam int BIT_ALARM_EN = 5;
	localparam int BIT_UPDATE_EN = 4;
	localparam int BIT_SQUARE_EN = 3;
	localparam int BIT_DATA_FORMAT = 2;
	localparam int BIT_HOUR_FORMAT = 1;
	localparam int BIT_DAYLIGHT = 0;
	localparam int BIT_IRQ_PENDING = 7;
	localparam int BIT_PERIODIC_FLAG = 6;
	localparam int BIT_ALARM_FLAG = 5;
	localparam int BIT_UPDATE_FLAG = 4;
	localparam int BIT_SLOW_CLK_EN = 2;
	localparam int BIT_VALID = 7;

	// ----------------------------------------------------------------
	// clock source control codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_RUN = 3'h2;
	localparam logic [2:0] SRC_RUN_FLAGS_RW = 3'h3;
	localparam logic [1:0] SRC_OSC_ONLY_HI = 2'h3;

	// ----------------------------------------------------------------
	// timing and widths
	// ----------------------------------------------------------------
	localparam int MCLK_HZ = 25_000_000;
	localparam int OSC_HZ = 32_768;
	localparam int DIV_W = 15;
	localparam logic [3:0] RATE_OFF = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [2:0] SRC_RESET_LO = 3'h0;

	typedef enum logic [1:0] {
		RTCC_IDLE,
		RTCC_UPDATING,
		RTCC_DONE
	} rtcc_upd_e;

endpackage

// ==== hw/rtcc_tick_gen.sv ====
// rtcc_tick_gen: turns mclk into a 32.768 khz oscillator enable pulse
// assumes mclk at MCLK_HZ; fractional accumulation keeps the mean rate
`timescale 1ns/1ps
module rtcc_tick_gen
	import rtcc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// control
	input wire logic osc_run,
	// tick out
	output logic osc_tick
);

	localparam logic [25:0] ACC_STEP = 26'(OSC_HZ);
	localparam logic [25:0] ACC_WRAP = 26'(MCLK_HZ);

	logic [25:0] acc;
	wire [25:0] acc_sum = acc + ACC_STEP;
	wire acc_over = acc_sum >= ACC_WRAP;
	wire [25:0] next_acc = acc_over ? acc_sum - ACC_WRAP : acc_sum;

	// phase accumulator; halts with the oscillator
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			acc <= 26'h0000000;
			osc_tick <= 1'b0;
		end else begin
			acc <= osc_run ? next_acc : acc;
			osc_tick <= osc_run & acc_over;
		end
	end

endmodule // rtcc_tick_gen

// ==== hw/rtcc_divider.sv ====
// rtcc_divider: 15-stage divider chain driven by oscillator ticks
// assumes osc_tick is a one-cycle enable at 32.768 khz
`timescale 1ns/1ps
module rtcc_divider
	import rtcc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// control
	input wire logic osc_tick,
	input wire logic div_run,
	// stage outputs
	output logic [DIV_W-1:0] stages,
	output logic second_tick
);

	wire [DIV_W-1:0] next_stages = stages + DIV_W'(1);

	// divider counts while enabled, holds reset otherwise
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stages <= '0;
			second_tick <= 1'b0;
		end else begin
			stages <= div_run ? (osc_tick ? next_stages : stages) : '0;
			second_tick <= div_run & osc_tick & (&stages);
		end
	end

endmodule // rtcc_divider

// ==== testbench/rtcc_ctrl_checker.sv ====
// rtcc_ctrl_checker: port-level properties of the rtc control block
// assumes the bench writes 0x0a and 0x0b before relying on them
`timescale 1ns/1ps
module rtcc_ctrl_checker
	import rtcc_pkg::*;
(
	// clock, reset, register port
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// status outputs
	input wire logic transfer_allow,
	input wire logic update_in_progress,
	input wire logic data_format,
	input wire logic hour_format,
	input wire logic daylight_saving_enable,
	input wire logic irq_req,
	input wire logic square_wave_output
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// shadow of the inhibit bit, never reset like the real one
	// ----------------------------------------------------------------
	logic inh;
	wire logic wr_fmt = reg_wr && (reg_addr == ADDR_IRQ_FMT);
	always_ff @(posedge mclk) begin
		if (wr_fmt)
			inh <= reg_wdata[BIT_TRANSFER_INHIBIT];
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_rdata_idle_zero: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read");
	a_unmapped_read: assert property (
		reg_rd && (reg_addr < ADDR_OSC_RATE || reg_addr > ADDR_INTEGRITY)
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_integrity_low_zero: assert property (
		reg_rd && reg_addr == ADDR_INTEGRITY |=> reg_rdata[6:0] == 7'h00)
		else $error("integrity low bits not zero");
	a_busy_bit_readback: assert property (
		reg_rd && reg_addr == ADDR_OSC_RATE
		|=> reg_rdata[7] == $past(update_in_progress))
		else $error("busy bit readback wrong");
	a_format_follows_write: assert property (
		wr_fmt |=> {data_format, hour_format, daylight_saving_enable}
		== $past(reg_wdata[2:0]))
		else $error("format outputs not written");
	a_pending_readback: assert property (
		reg_rd && reg_addr == ADDR_EVENTS |=> reg_rdata[7] == $past(irq_req))
		else $error("pending bit disagrees with request");
	a_inhibit_blocks: assert property (inh |-> !transfer_allow)
		else $error("transfer while inhibited");
	a_inhibit_clears_upd: assert property (
		(wr_fmt && reg_wdata[7]) ##1 !reg_wr
		##1 (reg_rd && reg_addr == ADDR_IRQ_FMT) |=> !reg_rdata[4])
		else $error("update enable kept under inhibit");
	c_irq: cover property (irq_req);
	c_flag_write: cover property (reg_wr && reg_addr == ADDR_EVENTS);
	c_square: cover property ($rose(square_wave_output));
endmodule // rtcc_ctrl_checker

bind rtcc_ctrl rtcc_ctrl_checker i_rtcc_ctrl_checker (.mclk(mclk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.transfer_allow(transfer_allow), .update_in_progress(update_in_progress),
	.data_format(data_format), .hour_format(hour_format),
	.daylight_saving_enable(daylight_saving_enable), .irq_req(irq_req),
	.square_wave_output(square_wave_output));

// ==== testbench/tb_rtcc_ctrl.sv ====
// tb_rtcc_ctrl: directed tests of the rtc control registers
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module tb_rtcc_ctrl;
	import rtcc_pkg::*;
	logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic alarm_match = 0, valid_in = 0, tg;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd;
	logic [7:0] reg_rdata;
	logic transfer_allow, second_tick, update_in_progress, data_format;
	logic hour_format, daylight_saving_enable, irq_req, square_wave_output;
	int err_total = 0, num_checks = 0;
	wire [2:0] fmt_bits = {data_format, hour_format, daylight_saving_enable};
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
	always #20 mclk = ~mclk;
	rtcc_ctrl i_rtcc_ctrl (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_match(alarm_match),
		.valid_ram_time_in(valid_in), .transfer_allow(transfer_allow),
		.second_tick(second_tick), .update_in_progress(update_in_progress),
		.data_format(data_format), .hour_format(hour_format),
		.daylight_saving_enable(daylight_saving_enable), .irq_req(irq_req),
		.square_wave_output(square_wave_output));
	// ----------------------------------------------------------------
	// bus and helper tasks
	// ----------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
		`CHK(n, e, rd)
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// square output changes within two oscillator ticks
	task sq_watch(output logic t);
		logic s;
		s = square_wave_output;
		t = 1'b0;
		repeat (1600) begin
			@(posedge mclk);
			#1 if (square_wave_output !== s) t = 1'b1;
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		wr(ADDR_OSC_RATE, 8'h7f); wr(ADDR_IRQ_FMT, 8'h0f);
		@(posedge mclk) sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		rchk("osc", ADDR_OSC_RATE, 8'h4f);
		rchk("fmt", ADDR_IRQ_FMT, 8'h07);
		rchk("flags", ADDR_EVENTS, 8'h00);
		$display("test reset done");
	endtask
	task t_readonly;
		wr(ADDR_OSC_RATE, 8'h80);
		rchk("busy", ADDR_OSC_RATE, 8'h00);
		wr(ADDR_EVENTS, 8'hff);
		rchk("flags", ADDR_EVENTS, 8'h00);
		wr(ADDR_INTEGRITY, 8'h00); valid_in <= 1'b1; cyc(4);
		rchk("valid", ADDR_INTEGRITY, 8'h80);
		valid_in <= 1'b0; cyc(4);
		rchk("novalid", ADDR_INTEGRITY, 8'h00);
		rchk("unmapped", 8'h20, 8'h00);
		$display("test readonly done");
	endtask
	task t_format;
		wr(ADDR_IRQ_FMT, 8'h07); cyc(1);
		`CHK("fmt", 3'h7, fmt_bits)
		wr(ADDR_IRQ_FMT, 8'h10);
		rchk("upd", ADDR_IRQ_FMT, 8'h10);
		wr(ADDR_IRQ_FMT, 8'h90);
		rchk("inh", ADDR_IRQ_FMT, 8'h80);
		`CHK("noxfer", 1'b0, transfer_allow)
		wr(ADDR_IRQ_FMT, 8'h00); cyc(1);
		`CHK("fmt0", 3'h0, fmt_bits)
		$display("test format done");
	endtask
	task t_flag_write;
		wr(ADDR_OSC_RATE, 8'h30); wr(ADDR_EVENTS, 8'h74);
		rchk("wflags", ADDR_EVENTS, 8'h74);
		rchk("cleared", ADDR_EVENTS, 8'h04);
		wr(ADDR_EVENTS, 8'h24); wr(ADDR_IRQ_FMT, 8'h20); cyc(1);
		`CHK("irq", 1'b1, irq_req)
		rchk("pend", ADDR_EVENTS, 8'ha4);
		sq_watch(tg);
		`CHK("slowclk", 1'b1, tg)
		wr(ADDR_EVENTS, 8'h14); cyc(1);
		`CHK("updmask", 1'b0, irq_req)
		wr(ADDR_IRQ_FMT, 8'h10); cyc(1);
		`CHK("updirq", 1'b1, irq_req)
		wr(ADDR_EVENTS, 8'h00); wr(ADDR_IRQ_FMT, 8'h00);
		$display("test flag write done");
	endtask
	task t_alarm;
		wr(ADDR_OSC_RATE, 8'h20); alarm_match <= 1'b1; cyc(5);
		`CHK("masked", 1'b0, irq_req)
		alarm_match <= 1'b0;
		rchk("alarm_flag", ADDR_EVENTS, 8'h20);
		wr(ADDR_IRQ_FMT, 8'h20); alarm_match <= 1'b1; cyc(5);
		`CHK("alarm", 1'b1, irq_req)
		alarm_match <= 1'b0;
		rchk("alarm_pend", ADDR_EVENTS, 8'ha0);
		wr(ADDR_IRQ_FMT, 8'h00);
		$display("test alarm done");
	endtask
	task t_square;
		wr(ADDR_OSC_RATE, 8'h2f); sq_watch(tg);
		`CHK("sqoff", 2'b00, {tg, square_wave_output})
		wr(ADDR_IRQ_FMT, 8'h08); sq_watch(tg);
		`CHK("sqon", 1'b1, tg)
		wr(ADDR_OSC_RATE, 8'h6f); sq_watch(tg); sq_watch(tg);
		`CHK("nodiv", 1'b0, tg)
		wr(ADDR_OSC_RATE, 8'h0f); sq_watch(tg); sq_watch(tg);
		`CHK("nosc", 1'b0, tg)
		`CHK("nosec", 1'b0, second_tick)
		wr(ADDR_OSC_RATE, 8'h20); sq_watch(tg); sq_watch(tg);
		`CHK("rate_off", 1'b0, tg)
		wr(ADDR_IRQ_FMT, 8'h00);
		$display("test square done");
	endtask
	task t_periodic;
		wr(ADDR_OSC_RATE, 8'h2f); cyc(1600);
		`CHK("permask", 1'b0, irq_req)
		wr(ADDR_IRQ_FMT, 8'h40);
		repeat (3000) begin
			@(posedge mclk);
			#1 if (irq_req === 1'b1) break;
		end
		`CHK("per", 1'b1, irq_req)
		rchk("periodic_flag", ADDR_EVENTS, 8'hc0);
		wr(ADDR_IRQ_FMT, 8'h00);
		$display("test periodic done");
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset; t_readonly; t_format; t_flag_write;
		t_alarm; t_square; t_periodic;
		test_done;
	end
	initial begin
		#(40 * 60000);
		err_total++;
		test_done;
	end
endmodule // tb_rtcc_ctrl
